// [src/pgm_pin_mux.sv]
// pin function multiplexer for ports g (1..0), h (6..0), j (7,6,3..0)
// assumes pad inputs synchronous to clk; tristate resolved outside
`default_nettype none

module pgm_pin_mux
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rstn,
  // pads
  input  wire logic [pgm_pkg::PGM_G_W-1:0]   pad_g_in,
  output var  logic [pgm_pkg::PGM_G_W-1:0]   pad_g_out,
  output var  logic [pgm_pkg::PGM_G_W-1:0]   pad_g_oe,
  input  wire logic [pgm_pkg::PGM_H_W-1:0]   pad_h_in,
  output var  logic [pgm_pkg::PGM_H_W-1:0]   pad_h_out,
  output var  logic [pgm_pkg::PGM_H_W-1:0]   pad_h_oe,
  input  wire logic [pgm_pkg::PGM_J_W-1:0]   pad_j_in,
  output var  logic [pgm_pkg::PGM_J_W-1:0]   pad_j_out,
  output var  logic [pgm_pkg::PGM_J_W-1:0]   pad_j_oe,
  // gpio control and readback
  input  wire logic [pgm_pkg::PGM_G_W-1:0]   gpio_dir_g,
  input  wire logic [pgm_pkg::PGM_G_W-1:0]   gpio_dat_g,
  output var  logic [pgm_pkg::PGM_G_W-1:0]   gpio_in_g,
  input  wire logic [pgm_pkg::PGM_H_W-1:0]   gpio_dir_h,
  input  wire logic [pgm_pkg::PGM_H_W-1:0]   gpio_dat_h,
  output var  logic [pgm_pkg::PGM_H_W-1:0]   gpio_in_h,
  input  wire logic [pgm_pkg::PGM_J_W-1:0]   gpio_dir_j,
  input  wire logic [pgm_pkg::PGM_J_W-1:0]   gpio_dat_j,
  output var  logic [pgm_pkg::PGM_J_W-1:0]   gpio_in_j,
  // key wakeup: enable, edge polarity (1 rising), clear pulse, flags
  input  wire logic [pgm_pkg::PGM_G_W-1:0]   wake_en_g,
  input  wire logic [pgm_pkg::PGM_H_W-1:0]   wake_en_h,
  input  wire logic [pgm_pkg::PGM_J_W-1:0]   wake_en_j,
  input  wire logic                          wake_pol_g,
  input  wire logic                          wake_pol_h,
  input  wire logic                          wake_pol_j,
  input  wire logic [pgm_pkg::PGM_G_W-1:0]   wake_clr_g,
  input  wire logic [pgm_pkg::PGM_H_W-1:0]   wake_clr_h,
  input  wire logic [pgm_pkg::PGM_J_W-1:0]   wake_clr_j,
  output var  logic [pgm_pkg::PGM_G_W-1:0]   wake_flag_g,
  output var  logic [pgm_pkg::PGM_H_W-1:0]   wake_flag_h,
  output var  logic [pgm_pkg::PGM_J_W-1:0]   wake_flag_j,
  output var  logic                          wake_irq,
  // ethernet mac unit, external mii
  input  wire logic                          mac_mii_en,
  output var  logic [1:0]                    mac_rxd,
  input  wire logic                          mac_tx_er,
  input  wire logic                          mac_tx_en,
  input  wire logic [3:0]                    mac_txd,
  output var  logic                          mac_tx_clk,
  output var  logic                          mac_col,
  output var  logic                          mac_crs,
  input  wire logic                          mac_mdio_out,
  input  wire logic                          mac_mdio_oe,
  output var  logic                          mac_mdio_in,
  input  wire logic                          mac_mdc,
  // two-wire serial unit, open drain: oe high pulls the line low
  input  wire logic                          tw_en,
  input  wire logic                          tw_scl_oe,
  input  wire logic                          tw_sda_oe,
  output var  logic                          tw_scl_in,
  output var  logic                          tw_sda_in
);
  import pgm_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] edge_hit(input logic [7:0] cur, input logic [7:0] prev,
                                          input logic pol);
    edge_hit = pol ? (cur & ~prev) : (~cur & prev);
  endfunction : edge_hit

  logic [PGM_G_W-1:0] g_oe_nxt;
  logic [PGM_G_W-1:0] g_out_nxt;
  logic [PGM_H_W-1:0] h_oe_nxt;
  logic [PGM_H_W-1:0] h_out_nxt;
  logic [PGM_J_W-1:0] j_oe_nxt;
  logic [PGM_J_W-1:0] j_out_nxt;
  logic [7:0]         g_edge;
  logic [7:0]         h_edge;
  logic [7:0]         j_edge;
  logic [PGM_J_W-1:0] j_in;
  logic               wake_arm_r;

  assign j_in = pad_j_in & PGM_J_MASK;

  // ----------------------------------------
  // output and direction selection
  // ----------------------------------------
  always_comb
  begin
    g_oe_nxt  = gpio_dir_g;
    g_out_nxt = gpio_dat_g;
    h_oe_nxt  = gpio_dir_h;
    h_out_nxt = gpio_dat_h;
    j_oe_nxt  = gpio_dir_j & PGM_J_MASK;
    j_out_nxt = gpio_dat_j & PGM_J_MASK;
    if (mac_mii_en)
    begin
      g_oe_nxt  = '0;
      h_oe_nxt[PGM_H_TXER]  = 1'b1;
      h_out_nxt[PGM_H_TXER] = mac_tx_er;
      h_oe_nxt[PGM_H_TXEN]  = 1'b1;
      h_out_nxt[PGM_H_TXEN] = mac_tx_en;
      h_oe_nxt[PGM_H_TXCLK]  = 1'b0;
      h_out_nxt[PGM_H_TXCLK] = 1'b0;
      h_oe_nxt[3:0]  = 4'hf;
      h_out_nxt[3:0] = mac_txd;
      j_oe_nxt[PGM_J_COL]  = 1'b0;
      j_oe_nxt[PGM_J_CRS]  = 1'b0;
      j_oe_nxt[PGM_J_MDIO]  = mac_mdio_oe;
      j_out_nxt[PGM_J_MDIO] = mac_mdio_out;
      j_oe_nxt[PGM_J_MDC]  = 1'b1;
      j_out_nxt[PGM_J_MDC] = mac_mdc;
    end
    if (tw_en)
    begin
      j_oe_nxt[PGM_J_SCL]  = tw_scl_oe;
      j_out_nxt[PGM_J_SCL] = 1'b0;
      j_oe_nxt[PGM_J_SDA]  = tw_sda_oe;
      j_out_nxt[PGM_J_SDA] = 1'b0;
    end
  end

  // ----------------------------------------
  // pad drivers
  // ----------------------------------------
  // drivers off in and after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pad_g_oe  <= PGM_G_RST;
      pad_g_out <= PGM_G_RST;
      pad_h_oe  <= PGM_H_RST;
      pad_h_out <= PGM_H_RST;
      pad_j_oe  <= PGM_J_RST;
      pad_j_out <= PGM_J_RST;
    end
    else
    begin
      pad_g_oe  <= g_oe_nxt;
      pad_g_out <= g_out_nxt;
      pad_h_oe  <= h_oe_nxt;
      pad_h_out <= h_out_nxt;
      pad_j_oe  <= j_oe_nxt;
      pad_j_out <= j_out_nxt;
    end
  end

  // ----------------------------------------
  // input capture
  // ----------------------------------------
  // gpio readback stays live in every mode so software can watch mii lines
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_in_g <= PGM_G_RST;
      gpio_in_h <= PGM_H_RST;
      gpio_in_j <= PGM_J_RST;
    end
    else
    begin
      gpio_in_g <= pad_g_in;
      gpio_in_h <= pad_h_in;
      gpio_in_j <= j_in;
    end
  end

  // peripheral inputs read zero (scl/sda idle high) while not enabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mac_rxd     <= 2'h0;
      mac_tx_clk  <= 1'b0;
      mac_col     <= 1'b0;
      mac_crs     <= 1'b0;
      mac_mdio_in <= 1'b0;
      tw_scl_in   <= 1'b1;
      tw_sda_in   <= 1'b1;
    end
    else
    begin
      mac_rxd     <= mac_mii_en ? pad_g_in : 2'h0;
      mac_tx_clk  <= mac_mii_en & pad_h_in[PGM_H_TXCLK];
      mac_col     <= mac_mii_en & pad_j_in[PGM_J_COL];
      mac_crs     <= mac_mii_en & pad_j_in[PGM_J_CRS];
      mac_mdio_in <= mac_mii_en & pad_j_in[PGM_J_MDIO];
      tw_scl_in   <= ~tw_en | pad_j_in[PGM_J_SCL];
      tw_sda_in   <= ~tw_en | pad_j_in[PGM_J_SDA];
    end
  end

  // ----------------------------------------
  // key wakeup
  // ----------------------------------------
  // edges are judged between the live pad and its last registered sample, so a glitch
  // shorter than one clock may be missed; no filtering is done
  assign g_edge = edge_hit({6'h00, pad_g_in}, {6'h00, gpio_in_g}, wake_pol_g)
                  & {8{wake_arm_r}};
  assign h_edge = edge_hit({1'b0, pad_h_in}, {1'b0, gpio_in_h}, wake_pol_h)
                  & {8{wake_arm_r}};
  assign j_edge = edge_hit(j_in, gpio_in_j, wake_pol_j)
                  & {8{wake_arm_r}};

  // no edge is judged on the first clock after reset: the sample register
  // still holds its reset zero, so a pin resting high would look like a rise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_arm_r <= 1'b0;
    else
      wake_arm_r <= 1'b1;
  end

  // sticky wakeup flags, set wins over clear
  // each flag fed by its own port bit, except j5, j4 and j0, which are never set
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_flag_g <= PGM_G_RST;
      wake_flag_h <= PGM_H_RST;
      wake_flag_j <= PGM_J_RST;
    end
    else
    begin
      wake_flag_g <= (wake_flag_g & ~wake_clr_g) | (g_edge[PGM_G_W-1:0] & wake_en_g);
      wake_flag_h <= (wake_flag_h & ~wake_clr_h) | (h_edge[PGM_H_W-1:0] & wake_en_h);
      wake_flag_j <= (wake_flag_j & ~wake_clr_j) | (j_edge & wake_en_j & PGM_J_WAKE);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_irq <= 1'b0;
    else
      wake_irq <= (|wake_flag_g) | (|wake_flag_h) | (|wake_flag_j);
  end

endmodule : pgm_pin_mux

`default_nettype wire

// [src/pgm_pkg.sv]
// constants for the port g/h/j pin function multiplexer
// assumes one 25 mhz clock and pad inputs already synchronous to it
`default_nettype none

package pgm_pkg;

  // ----------------------------------------
  // port widths and implemented bit masks
  // ----------------------------------------
  localparam int         PGM_G_W        = 2;
  localparam int         PGM_H_W        = 7;
  localparam int         PGM_J_W        = 8;
  localparam logic [7:0] PGM_J_MASK     = 8'hcf;
  localparam logic [7:0] PGM_J_WAKE     = 8'hce;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int         PGM_H_TXER     = 6;
  localparam int         PGM_H_TXEN     = 5;
  localparam int         PGM_H_TXCLK    = 4;
  localparam int         PGM_J_SCL      = 7;
  localparam int         PGM_J_SDA      = 6;
  localparam int         PGM_J_COL      = 3;
  localparam int         PGM_J_CRS      = 2;
  localparam int         PGM_J_MDIO     = 1;
  localparam int         PGM_J_MDC      = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0] PGM_G_RST      = 2'h0;
  localparam logic [6:0] PGM_H_RST      = 7'h00;
  localparam logic [7:0] PGM_J_RST      = 8'h00;

endpackage : pgm_pkg

`default_nettype wire

// [testbench/pgm_far_model.sv]
// far side: transceiver and two-wire devices on the pads
// assumes the bench gives the far level of every pin, {g, h, j}
`default_nettype none

module pgm_far_model
(
  // device drive
  input  wire logic [16:0] pad_out,
  input  wire logic [16:0] pad_oe,
  // far levels; on j7/j6 a 0 is another device pulling low
  input  wire logic [16:0] far_lvl,
  // resolved pin levels
  output wire logic [16:0] pad_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & far_lvl);
endmodule : pgm_far_model

`default_nettype wire

// [testbench/pgm_pin_mux_props.sv]
// concurrent checks on the pin function multiplexer ports
// assumes one clock domain, rstn asynchronous active low
`default_nettype none

module pgm_pin_mux_props
(
  // clock and reset
  input wire logic                         clk,
  input wire logic                         rstn,
  // pads
  input wire logic [pgm_pkg::PGM_G_W-1:0]  pad_g_oe,
  input wire logic [pgm_pkg::PGM_H_W-1:0]  pad_h_out,
  input wire logic [pgm_pkg::PGM_H_W-1:0]  pad_h_oe,
  input wire logic [pgm_pkg::PGM_J_W-1:0]  pad_j_in,
  input wire logic [pgm_pkg::PGM_J_W-1:0]  pad_j_out,
  input wire logic [pgm_pkg::PGM_J_W-1:0]  pad_j_oe,
  // wakeup
  input wire logic [pgm_pkg::PGM_H_W-1:0]  wake_flag_h,
  input wire logic                         wake_irq,
  // peripherals
  input wire logic                         mac_mii_en,
  input wire logic [3:0]                   mac_txd,
  input wire logic                         mac_col,
  input wire logic                         mac_mdc,
  input wire logic                         tw_en,
  input wire logic                         tw_sda_oe,
  input wire logic                         tw_scl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pgm_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_reset_hi_z: assert property (
    $rose(rstn) |-> {pad_g_oe, pad_h_oe, pad_j_oe} == 17'h00000) else $error("oe after reset");
  a_txd_nibble: assert property (
    mac_mii_en |=> pad_h_oe[3:0] == 4'hf && pad_h_out[3:0] == $past(mac_txd)) else $error("txd");
  a_tx_ctrl_dir: assert property (
    mac_mii_en |=> pad_h_oe[6:4] == 3'h6) else $error("tx ctrl dir");
  a_col_sample: assert property (
    mac_mii_en |=> mac_col == $past(pad_j_in[3])) else $error("col");
  a_mdc_drive: assert property (
    mac_mii_en |=> pad_j_oe[0] && pad_j_out[0] == $past(mac_mdc)) else $error("mdc");
  a_sda_pull: assert property (
    tw_en && tw_sda_oe |=> pad_j_oe[6] && !pad_j_out[6]) else $error("sda");
  a_scl_idle: assert property (
    !tw_en |=> tw_scl_in) else $error("scl idle");
  a_wake_irq: assert property (
    wake_flag_h != 7'h00 |=> wake_irq) else $error("irq");
endmodule : pgm_pin_mux_props

bind pgm_pin_mux pgm_pin_mux_props u_props (.*);

`default_nettype wire

// [testbench/port_ghj_pin_function_mux_tb.sv]
// self-checking bench for the pin function multiplexer
// assumes pgm_pkg, the design and the far-side model compiled first
`default_nettype none

module port_ghj_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pgm_pkg::*;

  logic         clk, rstn, mac_mii_en, tw_en;
  logic [16:0]  far_lvl, dir, dat, w_en, w_clr;
  logic [16:0]  e_oe, e_out, e_in, e_fl, ed, pm;
  logic [8:0]   mo;
  logic [5:0]   e_mi;
  logic [2:0]   pol;
  logic [1:0]   e_rx, tw_oe;
  logic         e_irq, e_arm;
  logic [76:0]  got_v, exp_v;
  // slices of these are driven by several instance ports, so they are nets
  wire  logic        irq;
  wire  logic [16:0] p_in, p_out, p_oe, g_in, fl;
  wire  logic [5:0]  mi;
  wire  logic [1:0]  rxd;
  logic [127:0] r;
  integer       seed = 32'h5667;
  int           miscompares = 0;
  int           checks_done = 0;

  pgm_far_model far_u (.pad_out(p_out), .pad_oe(p_oe), .far_lvl(far_lvl), .pad_lvl(p_in));

  pgm_pin_mux dut_u (
    .clk(clk), .rstn(rstn),
    .pad_g_in(p_in[16:15]), .pad_g_out(p_out[16:15]), .pad_g_oe(p_oe[16:15]),
    .pad_h_in(p_in[14:8]), .pad_h_out(p_out[14:8]), .pad_h_oe(p_oe[14:8]),
    .pad_j_in(p_in[7:0]), .pad_j_out(p_out[7:0]), .pad_j_oe(p_oe[7:0]),
    .gpio_dir_g(dir[16:15]), .gpio_dat_g(dat[16:15]), .gpio_in_g(g_in[16:15]),
    .gpio_dir_h(dir[14:8]), .gpio_dat_h(dat[14:8]), .gpio_in_h(g_in[14:8]),
    .gpio_dir_j(dir[7:0]), .gpio_dat_j(dat[7:0]), .gpio_in_j(g_in[7:0]),
    .wake_en_g(w_en[16:15]), .wake_en_h(w_en[14:8]), .wake_en_j(w_en[7:0]),
    .wake_pol_g(pol[2]), .wake_pol_h(pol[1]), .wake_pol_j(pol[0]),
    .wake_clr_g(w_clr[16:15]), .wake_clr_h(w_clr[14:8]), .wake_clr_j(w_clr[7:0]),
    .wake_flag_g(fl[16:15]), .wake_flag_h(fl[14:8]), .wake_flag_j(fl[7:0]),
    .wake_irq(irq), .mac_mii_en(mac_mii_en), .mac_rxd(rxd),
    .mac_tx_er(mo[8]), .mac_tx_en(mo[7]), .mac_txd(mo[6:3]), .mac_tx_clk(mi[5]),
    .mac_col(mi[4]), .mac_crs(mi[3]), .mac_mdio_out(mo[2]), .mac_mdio_oe(mo[1]),
    .mac_mdio_in(mi[2]), .mac_mdc(mo[0]), .tw_en(tw_en), .tw_scl_oe(tw_oe[1]),
    .tw_sda_oe(tw_oe[0]), .tw_scl_in(mi[1]), .tw_sda_in(mi[0])
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // reference model, one result per edge
  // ----------------------------------------
  assign pm = {{2{pol[2]}}, {7{pol[1]}}, {8{pol[0]}}};
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {e_oe, e_out, e_in, e_fl, e_irq, e_rx} = '0;
      e_mi = 6'h03;
      e_arm = 1'b0;
    end
    else
    begin
      // edge of the pin against its last sample
      e_irq = |e_fl;
      // no edge on the first clock after reset, the last sample is not real
      ed = (p_in ^ e_in) & ~(pm ^ p_in) & {17{e_arm}};
      e_fl = (e_fl & ~w_clr) | (ed & w_en & {9'h1ff, PGM_J_WAKE});
      e_arm = 1'b1;
      e_in = p_in & {9'h1ff, PGM_J_MASK};
      e_rx = mac_mii_en ? p_in[16:15] : 2'h0;
      e_mi = {mac_mii_en ? {p_in[12], p_in[3:1]} : 4'h0, tw_en ? p_in[7:6] : 2'h3};
      e_oe = dir & {9'h1ff, PGM_J_MASK};
      e_out = dat;
      if (mac_mii_en)
      begin
        e_oe[16:8] = 9'h06f;
        e_out[14:8] = {mo[8:7], 1'b0, mo[6:3]};
        e_oe[3:0] = {2'h0, mo[1], 1'b1};
        e_out[1:0] = {mo[2], mo[0]};
      end
      if (tw_en)
      begin
        e_oe[7:6] = tw_oe;
        e_out[7:6] = 2'h0;
      end
    end
  end

  assign got_v = {p_oe, p_out & p_oe, g_in, fl, irq, rxd, mi};
  assign exp_v = {e_oe, e_out & e_oe, e_in, e_fl, e_irq, e_rx, e_mi};

  always @(negedge clk)
  begin
    checks_done++;
    if (got_v !== exp_v)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got_v, exp_v);
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // all four mode pairs, random pins, one reset in mid-run
  initial
  begin
    {rstn, mac_mii_en, tw_en, far_lvl, dir, dat, w_en, w_clr, pol, mo, tw_oe} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int cyc = 0; cyc < 1200; cyc++)
    begin
      @(posedge clk);
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {dir, dat, w_en, far_lvl} <= r[67:0];
      w_clr <= r[84:68] & r[101:85];
      {pol, mo, tw_oe} <= r[115:102];
      {mac_mii_en, tw_en} <= cyc[8:7];
      rstn <= (cyc != 600);
    end
    finish_test();
  end

  initial
  begin
    #80000;
    miscompares++;
    finish_test();
  end
endmodule : port_ghj_pin_function_mux_tb

`default_nettype wire
